// *** hw/hbm_cfg.svh ***
`ifndef HBM_CFG_SVH
`define HBM_CFG_SVH

// bit position of the fast arbitration enable within dma_control_reg
`define HBM_FAST_ARB_BIT 1
// transfer_size codes
`define HBM_SIZ_WORD     2'h0
`define HBM_SIZ_LINE     2'h3
// cache line geometry and write fifo depth
`define HBM_LINE_BEATS   3'h4
`define HBM_ADDR_STEP    32'h4
`define HBM_FIFO_DEPTH   32

`endif

// *** hw/hbm_pkg.sv ***
package hbm_pkg;

  typedef enum logic [2:0] {
    HBM_IDLE  = 3'h0,
    HBM_ARB   = 3'h1,
    HBM_CTRL  = 3'h2,
    HBM_START = 3'h3,
    HBM_WAIT  = 3'h4,
    HBM_END   = 3'h5
  } hbm_state_t;

  typedef logic [1:0] hbm_tt_t;
  typedef logic [1:0] hbm_sc_t;
  typedef logic [2:0] hbm_tm_t;

endpackage

// *** hw/hbm_if.sv ***
`timescale 1ns/1ns

// word stream from the write fifo to the sequencer
interface hbm_stream_if #(parameter int W = 32, parameter int LW = 6);
  logic          valid;
  logic          ready;
  logic [W-1:0]  data;
  logic [LW-1:0] level;
  modport src (output valid, output data, output level, input ready);
  modport snk (input valid, input data, input level, output ready);
endinterface

// sequencer to arbitration unit
interface hbm_arb_if;
  logic want;
  logic fast;
  logic own;
  logic drop;
  modport ctl (output want, output fast, output drop, input own);
  modport arb (input want, input fast, input drop, output own);
endinterface

// *** hw/hbm_fifo.sv ***
`timescale 1ns/1ns

module hbm_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  hbm_stream_if.src         out
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;

  wire push = ce & in_valid & in_ready;
  wire pop  = ce & out.valid & out.ready;
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out.valid = (count != '0);
  assign out.data  = mem[rd_ptr];
  assign out.level = count;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end else if (ce) begin
      wr_ptr   <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr   <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count    <= next_count;
      in_ready <= (next_count != DEPTH[AW:0]);
    end
  end
endmodule

// *** hw/hbm_arb.sv ***
`timescale 1ns/1ns

module hbm_arb (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  hbm_arb_if.arb    a,
  input  wire logic grant_n,
  input  wire logic busy_i_n,
  output logic      request_n,
  output logic      busy_o_n,
  output logic      busy_oe_n,
  output logic      master_n
);
  logic req_q;
  logic own_q;

  // grant taken without a clock edge, whatever request and busy show
  wire fast_take = a.fast & a.want & ~a.drop & ~grant_n;
  wire norm_take = a.want & req_q & ~grant_n & busy_i_n;

  assign a.own     = own_q | fast_take;
  // request falls away in the same cycle that mastership appears, either way
  assign request_n = ~(req_q & ~a.own);
  assign master_n  = ~a.own;
  assign busy_oe_n = ~a.own;
  assign busy_o_n  = 1'b0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_q <= 1'b0;
      own_q <= 1'b0;
    end else if (ce) begin
      own_q <= ~a.drop & (own_q | fast_take | norm_take);
      req_q <= a.want & ~a.own & ~a.drop & ~norm_take;
    end
  end
endmodule

// *** hw/hbm_master.sv ***
// Overview of operation
// - fast mode: take mastership on grant leading edge, no clock edge needed
// - on fast mastership assert busy and master, drop request, asynchronously
// - after fast mastership, first transfer cycle starts at next clock edge
// - fast mode takes ownership on grant regardless of request and busy levels
// - non-mux master first drives direction, snoop, modifier and type
// - read: assert in-progress, then start with address and size for one cycle
// - non-mux write: drive write data with start, address and size
// - burst inhibit negated continues a line burst, else single transfers
// - error ack together with ack retries the bus cycle
// - error ack without ack raises a bus fault
// - clean ack with transfers left starts another start phase, except within a continuing line burst
// - after last acknowledged cycle drop master, busy and in-progress
// - end of non-mux read floats control and address
// - end of non-mux write floats control, address and data
// - mux mode drives function control instead of transfer modifier
// - mux read floats address when start ends, then awaits data
// - mux write floats data in address phase, then drives data
// - mux cycles drop data at the last ack, then master, busy and control together
// - fast arbitration bit is dma_control_reg bit 1
// - fetch indicator asserted during instruction fetch cycles
`timescale 1ns/1ns
`include "hbm_cfg.svh"

module hbm_master #(
  parameter int CW = 16,
  parameter int FD = `HBM_FIFO_DEPTH
) (
  input  wire logic            MCLK,
  input  wire logic            RST_N,
  input  wire logic            CLK_EN,
  input  wire logic [7:0]      DMA_CONTROL_REG,
  input  wire logic            REQ_VALID,
  output logic                 REQ_READY,
  input  wire logic            REQ_WRITE,
  input  wire logic            REQ_MUX,
  input  wire logic            REQ_BURST,
  input  wire logic            REQ_FETCH,
  input  wire logic [31:0]     REQ_ADDR,
  input  wire logic [CW-1:0]   REQ_COUNT,
  input  wire hbm_pkg::hbm_sc_t REQ_SNOOP,
  input  wire hbm_pkg::hbm_tm_t REQ_TM,
  input  wire hbm_pkg::hbm_tm_t REQ_FC,
  input  wire hbm_pkg::hbm_tt_t REQ_TT,
  input  wire logic            WR_VALID,
  output logic                 WR_READY,
  input  wire logic [31:0]     WR_DATA,
  output logic                 RD_VALID,
  output logic [31:0]          RD_DATA,
  output logic                 DONE,
  output logic                 FAULT,
  input  wire logic            BUS_GRANT_IN_N,
  output logic                 BUS_REQUEST_OUT_N,
  input  wire logic            BUS_BUSY_LINE_N_I,
  output logic                 BUS_BUSY_LINE_N_O,
  output logic                 BUS_BUSY_LINE_OE_N,
  output logic                 MASTER_N,
  output logic                 FETCH_N,
  input  wire logic            TRANSFER_ACK_IN_N,
  input  wire logic            TRANSFER_ERROR_ACK_N,
  input  wire logic            BURST_INHIBIT_IN_N,
  output logic                 CTRL_OE_N,
  output logic                 READ_WRITE_N,
  output hbm_pkg::hbm_sc_t     SNOOP_CONTROL,
  output hbm_pkg::hbm_tt_t     TRANSFER_TYPE,
  output hbm_pkg::hbm_tm_t     TRANSFER_MODIFIER,
  output logic                 TM_OE_N,
  output hbm_pkg::hbm_tm_t     FUNC_CTRL,
  output logic                 FC_OE_N,
  output logic                 TRANSFER_IN_PROGRESS_N,
  output logic                 TRANSFER_START_STROBE_N,
  output logic [31:0]          ADDR_O,
  output logic [1:0]           TRANSFER_SIZE,
  output logic                 ADDR_OE_N,
  input  wire logic [31:0]     DATA_I,
  output logic [31:0]          DATA_O,
  output logic                 DATA_OE_N
);
  import hbm_pkg::*;

  localparam int LW = $clog2(FD) + 1;

  hbm_state_t    state;
  logic          wr;
  logic          mux;
  logic          line;
  logic          burst;
  logic [2:0]    beat;
  logic [CW-1:0] left;
  logic [31:0]   addr;
  logic          want_line;
  logic          fresh;

  hbm_stream_if #(.W(32), .LW(LW)) wq ();
  hbm_arb_if arb ();

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  wire t_ack   = ~TRANSFER_ACK_IN_N & TRANSFER_ERROR_ACK_N;
  wire t_retry = ~TRANSFER_ACK_IN_N & ~TRANSFER_ERROR_ACK_N;
  wire t_fault = TRANSFER_ACK_IN_N & ~TRANSFER_ERROR_ACK_N;
  wire in_wait = (state == HBM_WAIT) & TRANSFER_START_STROBE_N;
  wire last    = (left == CW'(1));
  wire line_end = (beat == `HBM_LINE_BEATS - 3'h1);
  wire stay_line = (burst | (line & BURST_INHIBIT_IN_N)) & ~line_end;
  // fresh: DATA_O holds no unsent word; a retry resends the word already held
  wire wr_short = wr & fresh & ~wq.valid;
  wire [LW:0] wr_avail = {1'b0, wq.level} + {{LW{1'b0}}, ~fresh};
  wire line_ok = want_line & (addr[3:2] == 2'h0) & (left >= CW'(`HBM_LINE_BEATS))
               & (~wr | (wr_avail >= (LW+1)'(`HBM_LINE_BEATS)));
  wire take_ack = CLK_EN & in_wait & t_ack;
  // words leave the fifo as they are loaded, so a burst beat gets the next one
  wire load_first = CLK_EN & (state == HBM_START) & wr & fresh & wq.valid;
  wire load_next  = take_ack & wr & stay_line & ~last;

  assign arb.want = (state != HBM_IDLE) & (state != HBM_END);
  assign arb.fast = DMA_CONTROL_REG[`HBM_FAST_ARB_BIT];
  assign arb.drop = (state == HBM_END);
  assign wq.ready = load_first | load_next;

  hbm_fifo #(.W(32), .DEPTH(FD)) u_fifo (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .ce       (CLK_EN),
    .in_valid (WR_VALID),
    .in_ready (WR_READY),
    .in_data  (WR_DATA),
    .out      (wq)
  );

  hbm_arb u_arb (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .ce        (CLK_EN),
    .a         (arb),
    .grant_n   (BUS_GRANT_IN_N),
    .busy_i_n  (BUS_BUSY_LINE_N_I),
    .request_n (BUS_REQUEST_OUT_N),
    .busy_o_n  (BUS_BUSY_LINE_N_O),
    .busy_oe_n (BUS_BUSY_LINE_OE_N),
    .master_n  (MASTER_N)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state <= HBM_IDLE;
      {wr, mux, line, burst} <= 4'h0;
      want_line <= 1'b0;
      fresh <= 1'b1;
      beat <= 3'h0;
      left <= '0;
      addr <= 32'h0;
      REQ_READY <= 1'b1;
      {RD_VALID, DONE, FAULT} <= 3'h0;
      RD_DATA <= 32'h0;
      FETCH_N <= 1'b1;
      {CTRL_OE_N, TM_OE_N, FC_OE_N, ADDR_OE_N, DATA_OE_N} <= 5'h1F;
      READ_WRITE_N <= 1'b1;
      SNOOP_CONTROL <= 2'h0;
      TRANSFER_TYPE <= 2'h0;
      TRANSFER_MODIFIER <= 3'h0;
      FUNC_CTRL <= 3'h0;
      TRANSFER_IN_PROGRESS_N <= 1'b1;
      TRANSFER_START_STROBE_N <= 1'b1;
      ADDR_O <= 32'h0;
      TRANSFER_SIZE <= `HBM_SIZ_WORD;
      DATA_O <= 32'h0;
    end else if (CLK_EN) begin
      {RD_VALID, DONE, FAULT} <= 3'h0;
      unique case (state)
        HBM_IDLE: begin
          if (REQ_VALID && REQ_COUNT != '0) begin
            state <= HBM_ARB;
            REQ_READY <= 1'b0;
            {wr, mux, line, burst} <= {REQ_WRITE, REQ_MUX, 2'h0};
            addr <= REQ_ADDR;
            left <= REQ_COUNT;
            want_line <= REQ_BURST;
            fresh <= 1'b1;
            beat <= 3'h0;
            FETCH_N <= ~REQ_FETCH;
            READ_WRITE_N <= ~REQ_WRITE;
            SNOOP_CONTROL <= REQ_SNOOP;
            TRANSFER_TYPE <= REQ_TT;
            TRANSFER_MODIFIER <= REQ_TM;
            FUNC_CTRL <= REQ_FC;
          end
        end
        HBM_ARB: begin
          if (arb.own) begin
            state <= HBM_CTRL;
            CTRL_OE_N <= 1'b0;
            TM_OE_N <= mux;
            FC_OE_N <= ~mux;
          end
        end
        HBM_CTRL: begin
          state <= HBM_START;
          TRANSFER_IN_PROGRESS_N <= 1'b0;
        end
        HBM_START: begin
          if (!wr_short) begin
            state <= HBM_WAIT;
            line <= line_ok;
            burst <= 1'b0;
            beat <= 3'h0;
            TRANSFER_START_STROBE_N <= 1'b0;
            ADDR_O <= addr;
            ADDR_OE_N <= 1'b0;
            TRANSFER_SIZE <= line_ok ? `HBM_SIZ_LINE : `HBM_SIZ_WORD;
            fresh <= 1'b0;
            if (fresh) begin
              DATA_O <= wq.data;
            end
            DATA_OE_N <= ~(wr & ~mux);
          end
        end
        HBM_WAIT: begin
          if (!TRANSFER_START_STROBE_N) begin
            TRANSFER_START_STROBE_N <= 1'b1;
            ADDR_OE_N <= ADDR_OE_N | mux;
            DATA_OE_N <= ~wr;
          end else if (t_fault) begin
            FAULT <= 1'b1;
            state <= HBM_END;
            TRANSFER_IN_PROGRESS_N <= 1'b1;
            DATA_OE_N <= DATA_OE_N | mux;
          end else if (t_retry) begin
            state <= HBM_START;
          end else if (t_ack) begin
            RD_VALID <= ~wr;
            RD_DATA <= wr ? RD_DATA : DATA_I;
            left <= left - CW'(1);
            addr <= addr + `HBM_ADDR_STEP;
            beat <= beat + 3'h1;
            burst <= stay_line;
            fresh <= ~stay_line;
            if (last) begin
              state <= HBM_END;
              TRANSFER_IN_PROGRESS_N <= 1'b1;
              DATA_OE_N <= DATA_OE_N | mux;
            end else if (stay_line) begin
              DATA_O <= wq.data;
            end else begin
              state <= HBM_START;
            end
          end
        end
        HBM_END: begin
          state <= HBM_IDLE;
          REQ_READY <= 1'b1;
          DONE <= 1'b1;
          FETCH_N <= 1'b1;
          {CTRL_OE_N, TM_OE_N, FC_OE_N} <= 3'h7;
          ADDR_OE_N <= 1'b1;
          DATA_OE_N <= 1'b1;
          TRANSFER_SIZE <= `HBM_SIZ_WORD;
        end
        default: state <= HBM_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence s_ts_pulse;
    !TRANSFER_START_STROBE_N ##1 TRANSFER_START_STROBE_N;
  endsequence

  sequence s_own_to_ctrl;
    (state == HBM_ARB) && arb.own && CLK_EN ##1 (state == HBM_CTRL) && !CTRL_OE_N;
  endsequence

  a_ts_one_cycle: assert property (
    $fell(TRANSFER_START_STROBE_N) && CLK_EN |-> s_ts_pulse)
    else $error("start strobe held longer than one cycle");
  a_tip_with_ts: assert property (
    !TRANSFER_START_STROBE_N |-> !TRANSFER_IN_PROGRESS_N && !ADDR_OE_N)
    else $error("start strobe without in-progress or address");
  a_write_data_ts: assert property (
    !TRANSFER_START_STROBE_N && wr && !mux |-> !DATA_OE_N && !CTRL_OE_N)
    else $error("non-mux write data not driven with start");
  a_pop_load: assert property (
    CLK_EN && wq.ready |=> DATA_O == $past(wq.data))
    else $error("write word not loaded as it left the fifo");
  a_mux_data_float: assert property (
    !TRANSFER_START_STROBE_N && mux |-> DATA_OE_N)
    else $error("mux data driven during address phase");
  a_mux_addr_float: assert property (
    mux && $rose(TRANSFER_START_STROBE_N) |-> ADDR_OE_N)
    else $error("mux address still driven after start");
  a_fault_pulse: assert property (
    CLK_EN && in_wait && t_fault |=> FAULT && state == HBM_END ##1 DONE)
    else $error("bus fault not raised");
  a_retry_restart: assert property (
    CLK_EN && in_wait && t_retry |=> state == HBM_START && !FAULT)
    else $error("retry did not restart the cycle");
  a_read_capture: assert property (
    take_ack && !wr |=> RD_VALID && RD_DATA == $past(DATA_I))
    else $error("read data not captured on ack");
  a_own_to_ctrl: assert property (
    (state == HBM_ARB) && arb.own && CLK_EN |-> s_own_to_ctrl)
    else $error("transfer did not begin after mastership");
  a_end_float: assert property (
    (state == HBM_END) && CLK_EN |=> ADDR_OE_N && CTRL_OE_N && DATA_OE_N && MASTER_N)
    else $error("lines not released at end");
  a_mux_no_tm: assert property (
    !CTRL_OE_N |-> (TM_OE_N == mux) && (FC_OE_N == !mux))
    else $error("modifier and function control enables wrong");
  a_fast_grant: assert property (
    arb.fast && arb.want && !arb.drop && !BUS_GRANT_IN_N |-> !MASTER_N
      && !BUS_BUSY_LINE_OE_N && BUS_REQUEST_OUT_N)
    else $error("fast grant not taken at once");
endmodule

// *** test/hbm_host_model.sv ***
`timescale 1ns/1ns

module hbm_host_model (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        REQ_N,
  input  wire logic        MST_N,
  input  wire logic        TS_N,
  input  wire logic        RW_N,
  input  wire logic [31:0] ADDR,
  input  wire logic [1:0]  SIZ,
  input  wire logic [31:0] DO,
  input  wire logic [3:0]  WT,
  input  wire logic        INH,
  output logic             GNT_N,
  output logic             TA_N,
  output logic             TEA_N,
  output logic             TBI_N,
  output logic [31:0]      DI
);
  logic [31:0] mem [0:63];
  logic [31:0] a;
  int          n;
  int          err;

  initial begin
    GNT_N = 1'b1;
    TA_N = 1'b1;
    TEA_N = 1'b1;
    DI = 32'h0;
    err = 0;
  end

  assign TBI_N = ~INH;

  // ----------------------------------------
  // arbiter: grant after request, kept while master
  // ----------------------------------------
  always @(posedge MCLK) begin
    if (!RST_N)
      GNT_N <= #1 1'b1;
    else if (!REQ_N)
      GNT_N <= #1 1'b0;
    else if (MST_N)
      GNT_N <= #1 1'b1;
  end

  // ----------------------------------------
  // memory: ends each cycle, err is one-shot (1 retry, 2 fault)
  // ----------------------------------------
  always begin
    @(posedge MCLK);
    if (RST_N && !TS_N) begin
      a = ADDR;
      n = (SIZ == 2'h3 && !INH) ? 4 : 1;
      repeat (WT + 1) @(posedge MCLK);
      for (int i = 0; i < n; i++) begin
        #1;
        TA_N = (err == 2);
        TEA_N = (err == 0);
        DI = mem[a[7:2]];
        @(posedge MCLK);
        if (err != 0)
          n = 0;
        else if (!RW_N)
          mem[a[7:2]] = DO;
        err = 0;
        a = a + 32'h4;
        #1;
        TA_N = 1'b1;
        TEA_N = 1'b1;
        DI = ~DI;
        if (i < n - 1)
          repeat (WT) @(posedge MCLK);
      end
    end
  end
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module tb_top;
  import hbm_pkg::*;
  logic MCLK, RST_N, CLK_EN, REQ_VALID, REQ_READY, REQ_WRITE, REQ_MUX, REQ_BURST, REQ_FETCH;
  logic WR_VALID, WR_READY, RD_VALID, DONE, FAULT, BUS_GRANT_IN_N, BUS_REQUEST_OUT_N;
  logic BUS_BUSY_LINE_N_I, BUS_BUSY_LINE_N_O, BUS_BUSY_LINE_OE_N, MASTER_N, FETCH_N;
  logic TRANSFER_ACK_IN_N, TRANSFER_ERROR_ACK_N, BURST_INHIBIT_IN_N, CTRL_OE_N, READ_WRITE_N;
  logic TM_OE_N, FC_OE_N, TRANSFER_IN_PROGRESS_N, TRANSFER_START_STROBE_N, ADDR_OE_N, DATA_OE_N;
  logic [7:0]  DMA_CONTROL_REG;
  logic [15:0] REQ_COUNT;
  logic [31:0] REQ_ADDR, WR_DATA, RD_DATA, ADDR_O, DATA_I, DATA_O, t_addr;
  logic [1:0]  TRANSFER_SIZE, t_siz;
  hbm_sc_t     REQ_SNOOP, SNOOP_CONTROL, t_sc;
  hbm_tm_t     REQ_TM, REQ_FC, TRANSFER_MODIFIER, FUNC_CTRL, t_tm, t_fc;
  hbm_tt_t     REQ_TT, TRANSFER_TYPE, t_tt;
  logic        t_rw, t_doe, t_tmoe, t_fcoe, t_fetch, t_tip, p_aoe, p_doe, ts_d, inh;
  logic [3:0]  wt;
  logic [31:0] rdq [$];
  int          fails, checks_done, ts_cnt, flt_cnt;

  // busy line has a pull-up
  assign BUS_BUSY_LINE_N_I = BUS_BUSY_LINE_OE_N ? 1'b1 : BUS_BUSY_LINE_N_O;

  hbm_master DUT (.MCLK, .RST_N, .CLK_EN, .DMA_CONTROL_REG, .REQ_VALID, .REQ_READY, .REQ_WRITE,
    .REQ_MUX, .REQ_BURST, .REQ_FETCH, .REQ_ADDR, .REQ_COUNT, .REQ_SNOOP, .REQ_TM, .REQ_FC,
    .REQ_TT, .WR_VALID, .WR_READY, .WR_DATA, .RD_VALID, .RD_DATA, .DONE, .FAULT,
    .BUS_GRANT_IN_N, .BUS_REQUEST_OUT_N, .BUS_BUSY_LINE_N_I, .BUS_BUSY_LINE_N_O,
    .BUS_BUSY_LINE_OE_N, .MASTER_N, .FETCH_N, .TRANSFER_ACK_IN_N, .TRANSFER_ERROR_ACK_N,
    .BURST_INHIBIT_IN_N, .CTRL_OE_N, .READ_WRITE_N, .SNOOP_CONTROL, .TRANSFER_TYPE,
    .TRANSFER_MODIFIER, .TM_OE_N, .FUNC_CTRL, .FC_OE_N, .TRANSFER_IN_PROGRESS_N,
    .TRANSFER_START_STROBE_N, .ADDR_O, .TRANSFER_SIZE, .ADDR_OE_N, .DATA_I, .DATA_O, .DATA_OE_N);

  hbm_host_model host (.MCLK, .RST_N, .REQ_N(BUS_REQUEST_OUT_N), .MST_N(MASTER_N),
    .TS_N(TRANSFER_START_STROBE_N), .RW_N(READ_WRITE_N), .ADDR(ADDR_O), .SIZ(TRANSFER_SIZE),
    .DO(DATA_O), .WT(wt), .INH(inh), .GNT_N(BUS_GRANT_IN_N), .TA_N(TRANSFER_ACK_IN_N),
    .TEA_N(TRANSFER_ERROR_ACK_N), .TBI_N(BURST_INHIBIT_IN_N), .DI(DATA_I));

  // ----------------------------------------
  // bus monitor
  // ----------------------------------------
  always @(posedge MCLK) begin
    ts_d <= !TRANSFER_START_STROBE_N;
    if (!TRANSFER_START_STROBE_N) begin
      ts_cnt++;
      {t_addr, t_siz, t_rw, t_doe, t_tip} = {ADDR_O, TRANSFER_SIZE, READ_WRITE_N, DATA_OE_N,
        TRANSFER_IN_PROGRESS_N};
      {t_sc, t_tm, t_tt, t_fc, t_tmoe, t_fcoe, t_fetch} = {SNOOP_CONTROL, TRANSFER_MODIFIER,
        TRANSFER_TYPE, FUNC_CTRL, TM_OE_N, FC_OE_N, FETCH_N};
    end
    if (ts_d)
      {p_aoe, p_doe} = {ADDR_OE_N, DATA_OE_N};
    if (RD_VALID)
      rdq.push_back(RD_DATA);
    if (FAULT)
      flt_cnt++;
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic job(input logic w, m, b, f, fast, input logic [31:0] ad, input int c);
    int k;
    ts_cnt = 0;
    flt_cnt = 0;
    rdq.delete();
    @(posedge MCLK);
    #1;
    DMA_CONTROL_REG = {6'h0, fast, 1'b0};
    {REQ_WRITE, REQ_MUX, REQ_BURST, REQ_FETCH, REQ_ADDR} = {w, m, b, f, ad};
    REQ_COUNT = c[15:0];
    REQ_VALID = 1'b1;
    do @(posedge MCLK); while (REQ_READY !== 1'b1);
    #1;
    REQ_VALID = 1'b0;
    k = 0;
    while (DONE !== 1'b1 && FAULT !== 1'b1 && k < 3000) begin
      @(posedge MCLK);
      k++;
    end
    `CHK("job_end", 1, int'(k < 3000))
    repeat (3) @(posedge MCLK);
    #1;
  endtask

  task automatic fill(input int n, input logic [31:0] base);
    @(posedge MCLK);
    #1;
    for (int i = 0; i < n; i++) begin
      WR_DATA = base + i;
      WR_VALID = 1'b1;
      do @(posedge MCLK); while (WR_READY !== 1'b1);
      #1;
    end
    WR_VALID = 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rd(input logic fast);
    fork
      job(0, 0, 0, 0, fast, 32'h10, 1);
      begin
        @(negedge BUS_GRANT_IN_N);
        #1;
        `CHK("master_async", !fast, MASTER_N)
        if (fast) begin
          `CHK("req_drop", 1'b1, BUS_REQUEST_OUT_N)
          `CHK("busy_drive", 1'b0, BUS_BUSY_LINE_OE_N)
          @(posedge MCLK);
          #1;
          `CHK("ctrl_next", 1'b0, CTRL_OE_N)
        end
      end
    join
    `CHK("ts_cnt", 1, ts_cnt)
    `CHK("ts_addr", 32'h10, t_addr)
    `CHK("ts_siz", 2'h0, t_siz)
    `CHK("ts_tip", 1'b0, t_tip)
    `CHK("ts_rw", 1'b1, t_rw)
    `CHK("ctl", {2'h1, 3'h5, 2'h2, 1'b0, 1'b1}, {t_sc, t_tm, t_tt, t_tmoe, t_fcoe})
    `CHK("fetch", 1'b1, t_fetch)
    `CHK("rd", 32'hA5000004, rdq[0])
    `CHK("end_oe", 4'hF, {MASTER_N, CTRL_OE_N, ADDR_OE_N, TRANSFER_IN_PROGRESS_N})
    $display("test read fast=%0d done", fast);
  endtask

  task automatic t_inh;
    inh = 1'b1;
    job(0, 0, 1, 0, 0, 32'h40, 4);
    inh = 1'b0;
    `CHK("ts_cnt", 4, ts_cnt)
    `CHK("ts_addr", 32'h4C, t_addr)
    `CHK("rd_n", 4, rdq.size())
    for (int i = 0; i < 4; i++)
      `CHK("rd", 32'hA5000010 + i, rdq[i])
    job(0, 0, 1, 0, 0, 32'h40, 4);
    `CHK("line_ts", 1, ts_cnt)
    `CHK("line_siz", 2'h3, t_siz)
    for (int i = 0; i < 4; i++)
      `CHK("line_rd", 32'hA5000010 + i, rdq[i])
    $display("test inhibit done");
  endtask

  task automatic t_err;
    host.err = 1;
    job(0, 0, 0, 0, 0, 32'h20, 1);
    `CHK("retry_ts", 2, ts_cnt)
    `CHK("retry_rd", 32'hA5000008, rdq[0])
    `CHK("retry_flt", 0, flt_cnt)
    host.err = 2;
    job(0, 0, 0, 0, 0, 32'h20, 1);
    `CHK("fault", 1, flt_cnt)
    `CHK("fault_rd", 0, rdq.size())
    `CHK("fault_rel", 1'b1, MASTER_N)
    $display("test error done");
  endtask

  task automatic t_wrb;
    wt = 4'h2;
    fill(32, 32'hC0000000);
    `CHK("fifo_full", 1'b0, WR_READY)
    job(1, 0, 1, 0, 0, 32'h0, 32);
    wt = 4'h0;
    `CHK("ts_cnt", 8, ts_cnt)
    `CHK("ts_siz", 2'h3, t_siz)
    `CHK("ts_doe", 1'b0, t_doe)
    for (int i = 0; i < 32; i++)
      `CHK("mem", 32'hC0000000 + i, host.mem[i])
    `CHK("end_oe", 3'h7, {CTRL_OE_N, ADDR_OE_N, DATA_OE_N})
    `CHK("fifo_empty", 1'b1, WR_READY)
    $display("test write burst done");
  endtask

  task automatic t_mux;
    fill(1, 32'hD0000000);
    job(1, 1, 0, 0, 0, 32'h80, 1);
    `CHK("mux_ctl", {1'b1, 1'b0, 3'h6}, {t_tmoe, t_fcoe, t_fc})
    `CHK("mux_wd", 3'h6, {t_doe, p_aoe, p_doe})
    `CHK("mux_mem", 32'hD0000000, host.mem[32])
    `CHK("mux_end", 2'h3, {MASTER_N, BUS_BUSY_LINE_OE_N})
    job(0, 1, 0, 1, 0, 32'h84, 1);
    `CHK("mux_rd_oe", 2'h3, {p_aoe, p_doe})
    `CHK("mux_rd", 32'hA5000021, rdq[0])
    `CHK("fetch", 1'b0, t_fetch)
    `CHK("mux_end_d", 2'h3, {CTRL_OE_N, DATA_OE_N})
    $display("test mux done");
  endtask

  task automatic end_sim;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  initial begin
    #200000;
    fails++;
    $display("[ERR] watchdog exp done got hang");
    end_sim();
  end

  initial begin
    {RST_N, REQ_VALID, REQ_WRITE, REQ_MUX, REQ_BURST, REQ_FETCH, WR_VALID, inh} = 8'h0;
    {CLK_EN, DMA_CONTROL_REG, REQ_ADDR, REQ_COUNT, WR_DATA, wt} = {1'b1, 92'h0};
    {REQ_SNOOP, REQ_TM, REQ_FC, REQ_TT} = {2'h1, 3'h5, 3'h6, 2'h2};
    for (int i = 0; i < 64; i++)
      host.mem[i] = 32'hA5000000 + i;
    repeat (4) @(posedge MCLK);
    #1;
    RST_N = 1'b1;
    `CHK("rst_idle", 8'hFF, {REQ_READY, WR_READY, MASTER_N, BUS_REQUEST_OUT_N, CTRL_OE_N,
      ADDR_OE_N, DATA_OE_N, BUS_BUSY_LINE_OE_N})
    t_rd(1'b0);
    t_rd(1'b1);
    t_inh();
    t_err();
    t_wrb();
    t_mux();
    end_sim();
  end
endmodule
